// file: dv/boundary_test_exec_asserts.sv
// Port-level assertions for the boundary test execution block.
`timescale 1ns/1ps

module boundary_test_exec_asserts (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire bscan_pkg::tap_s tap_i,
  input wire logic [7:0] instr_i,
  input wire logic tdi_i,
  input wire logic tdo_o,
  input wire logic dir_i,
  input wire logic oe_n_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] a_o,
  input wire logic a_oe_o,
  input wire logic [7:0] b_i,
  input wire logic [7:0] b_o,
  input wire logic b_oe_o,
  input wire logic test_mode_o
);
  logic [6:0] op;
  logic nrm;
  logic tst;
  logic byp;

  // Opcode classes; the top instruction bit plays no part.
  assign op = instr_i[6:0];
  assign nrm = op inside {7'h01, 7'h02, 7'h04, 7'h05, 7'h08, 7'h0a, 7'h0c,
                          7'h0e} || op > 7'h0f;
  assign tst = op inside {7'h00, 7'h03, 7'h07, 7'h09, 7'h0b, 7'h0d, 7'h0f};
  assign byp = !(op inside {7'h00, 7'h02, 7'h03, 7'h0a, 7'h0b, 7'h0c,
                            7'h0e, 7'h0f});

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence shift_out;
    tap_i.tck_fall && tap_i.shift_dr;
  endsequence
  sequence byp_cap;
    byp && tap_i.tck_rise && tap_i.capture_dr;
  endsequence
  sequence byp_shift;
    byp && tap_i.tck_rise && tap_i.shift_dr;
  endsequence
  // Pins and opcode quiet long enough to flush the synchronisers.
  sequence steady;
    (op inside {7'h01, 7'h02} && $stable(a_i) && $stable(b_i) &&
     $stable(dir_i) && $stable(oe_n_i)) [*5];
  endsequence

  bypass_cap_a:
    assert property (byp_cap ##2 shift_out |=> tdo_o == 1'b0)
    else $error("Bypass bit did not capture zero.");
  byp_shift_a:
    assert property (byp_shift ##2 shift_out |=> tdo_o == $past(tdi_i, 3))
    else $error("Bypass bit did not pass scan data.");
  tdo_hold_a:
    assert property (!(tap_i.tck_fall && tap_i.shift_dr) |=> $stable(tdo_o))
    else $error("Scan output moved outside a shift.");
  tm_test_a:
    assert property (tst |-> test_mode_o)
    else $error("Test mode missing.");
  tm_normal_a:
    assert property (nrm |-> !test_mode_o)
    else $error("Normal mode missing.");
  highz_oe_a:
    assert property ((op == 7'h06) [*4] |-> !a_oe_o && !b_oe_o)
    else $error("Outputs driven under high impedance.");
  normal_xcvr_a:
    assert property (steady |-> (oe_n_i ? !a_oe_o && !b_oe_o : dir_i ?
      b_oe_o && !a_oe_o && b_o == a_i : a_oe_o && !b_oe_o && a_o == b_i))
    else $error("Transceiver path wrong in normal mode.");
  test_pins_a:
    assert property ((op inside {7'h00, 7'h03, 7'h07} && !tap_i.tck_fall)
      [*6] |-> $stable(b_o) && $stable(a_oe_o) && $stable(b_oe_o))
    else $error("Test pins moved without an update.");
endmodule : boundary_test_exec_asserts

bind boundary_test_exec boundary_test_exec_asserts i_asserts (.clk_i,
  .resetn_i, .tap_i, .instr_i, .tdi_i, .tdo_o, .dir_i, .oe_n_i, .a_i, .a_o,
  .a_oe_o, .b_i, .b_o, .b_oe_o, .test_mode_o);

// file: dv/tap_ctrl_model.sv
// Model of the external test controller that walks the access port.
`timescale 1ns/1ps

module tap_ctrl_model (
  input wire logic clk_i,
  input wire logic tdo_i,
  output bscan_pkg::tap_s tap_o,
  output logic tdi_o
);
  // Idle controller: no edges, no state level.
  initial begin
    tap_o = '0;
    tdi_o = 1'b0;
  end

  // One test clock period: fall, wait, rise, wait. State and data change
  // with the fall and are held through the rise, as a real controller does.
  task automatic tck(input logic [4:0] st, input logic d, output logic q);
    @(negedge clk_i);
    tap_o <= {2'b01, st};
    tdi_o <= d;
    @(negedge clk_i);
    q = tdo_i;
    tap_o.tck_fall <= 1'b0;
    @(negedge clk_i);
    tap_o.tck_rise <= 1'b1;
    @(negedge clk_i);
    tap_o.tck_rise <= 1'b0;
  endtask : tck

  // Data scan: capture, n shifts LSB first, exit, update, select.
  // Outside the shift the data line carries the inverse of its last value.
  task automatic scan(input int n, input logic [17:0] din,
                      output logic [17:0] dout);
    logic q;
    dout = '0;
    tck(5'h08, ~tdi_o, q);
    for (int i = 0; i < n; i++) begin
      tck(5'h04, din[i], q);
      dout[i] = q;
    end
    tck(5'h00, ~tdi_o, q);
    tck(5'h02, ~tdi_o, q);
    tck(5'h00, ~tdi_o, q);
  endtask : scan

  // Hold one state level for n test clock periods.
  task automatic idle(input int n, input logic [4:0] st);
    logic q;
    repeat (n) tck(st, ~tdi_o, q);
  endtask : idle
endmodule : tap_ctrl_model

// file: dv/testbench.sv
// Self-checking bench for the boundary test instruction logic.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("[ERR] %0t got %h want %h", $time, a, e); end end

module testbench;
  localparam logic [17:0] SEED = 18'h2a5c3;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] instr_i = 8'h01;
  logic dir_i = 1'b1;
  logic oe_n_i = 1'b0;
  logic [7:0] a_i = 8'h5a;
  logic [7:0] b_i = 8'h3c;
  logic tdi_i, tdo_o, a_oe_o, b_oe_o, test_mode_o;
  logic [7:0] a_o, b_o;
  bscan_pkg::tap_s tap_i;
  logic [17:0] q;
  int miscompares = 0;
  int total_checks = 0;

  // System clock, 4 ns period.
  always #2 clk_i = ~clk_i;

  tap_ctrl_model i_tap_ctrl_model (.clk_i, .tdo_i(tdo_o), .tap_o(tap_i),
    .tdi_o(tdi_i));
  boundary_test_exec i_boundary_test_exec (.clk_i, .resetn_i, .tap_i,
    .instr_i, .tdi_i, .tdo_o, .dir_i, .oe_n_i, .a_i, .a_o, .a_oe_o, .b_i,
    .b_o, .b_oe_o, .test_mode_o);

  task automatic set_ir(input logic [7:0] c);
    @(negedge clk_i);
    instr_i = c;
  endtask : set_ir

  // Expected chain bits 15..0 after one run step; k 4 means toggle only.
  function automatic logic [15:0] step(input logic [15:0] c, input int k);
    logic [15:0] g;
    logic [7:0] h;
    logic [7:0] l;
    g = {c[14:0], 1'b0} ^ (c[15] ? bscan_pkg::POLY16 : 16'h0000);
    h = {c[14:8], 1'b0} ^ (c[15] ? bscan_pkg::POLY8 : 8'h00) ^ a_i;
    l = {c[6:0], 1'b0} ^ (c[7] ? bscan_pkg::POLY8 : 8'h00);
    case (k)
      0: step = {a_i, ~c[7:0]};
      1: step = g;
      2: step = g ^ {a_i, 8'h00};
      3: step = {h, l};
      default: step = {c[15:8], ~c[7:0]};
    endcase
  endfunction : step

  task automatic t_select();
    set_ir(8'h0e);
    i_tap_ctrl_model.scan(2, 18'h1, q);
    `CHK(q[1:0], 2'b10)
    set_ir(8'h8f);
    i_tap_ctrl_model.scan(2, 18'h3, q);
    `CHK(q[1:0], 2'b01)
    i_tap_ctrl_model.idle(1, 5'h10);
    i_tap_ctrl_model.scan(2, 18'h0, q);
    `CHK(q[1:0], 2'b10)
  endtask : t_select

  task automatic t_bypass();
    logic [7:0] codes [6] = '{8'h81, 8'h06, 8'h87, 8'h09, 8'h8d, 8'h7f};
    foreach (codes[i]) begin
      set_ir(codes[i]);
      i_tap_ctrl_model.scan(2, 18'h1, q);
      `CHK(q[1:0], 2'b10)
    end
  endtask : t_bypass

  task automatic t_pins();
    set_ir(8'h02);
    i_tap_ctrl_model.scan(18, SEED, q);
    `CHK(q, {2'b10, 8'h5a, 8'h5a})
    `CHK({b_oe_o, a_oe_o, b_o}, {2'b10, 8'h5a})
    set_ir(8'h80);
    repeat (8) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o, b_o}, {2'b10, SEED[7:0]})
    set_ir(8'h06);
    repeat (8) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o}, 2'b00)
    set_ir(8'h07);
    repeat (8) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o, b_o}, {2'b10, SEED[7:0]})
  endtask : t_pins

  task automatic t_self();
    set_ir(8'h0c);
    i_tap_ctrl_model.scan(18, SEED, q);
    i_tap_ctrl_model.scan(18, SEED, q);
    `CHK(q, ~SEED)
    set_ir(8'h0a);
    i_tap_ctrl_model.scan(18, SEED, q);
    `CHK(q, SEED)
  endtask : t_self

  // Load the select code and a nonzero seed first.
  task automatic t_run();
    logic [15:0] c;
    logic [15:0] p;
    for (int k = 0; k < 5; k++) begin
      set_ir(8'h0e);
      i_tap_ctrl_model.scan(2, 18'(k), q);
      set_ir(8'h02);
      i_tap_ctrl_model.scan(18, SEED, q);
      set_ir(k == 4 ? 8'h0d : 8'h09);
      i_tap_ctrl_model.idle(3, 5'h01);
      c = SEED[15:0];
      // Pins trail the shift stages by one step: a fall precedes each rise.
      repeat (3) begin
        p = c;
        c = step(c, k);
      end
      `CHK(b_o, k == 2 ? SEED[7:0] : p[7:0])
      set_ir(8'h0b);
      i_tap_ctrl_model.scan(18, 18'h0, q);
      `CHK(q, {SEED[17:16], c})
    end
  endtask : t_run

  // Normal mode towards A, isolation, then the control cells under clamp.
  task automatic t_dir();
    set_ir(8'h01);
    dir_i = 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o, a_o}, {2'b01, 8'h3c})
    oe_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o}, 2'b00)
    set_ir(8'h02);
    i_tap_ctrl_model.scan(18, 18'h00096, q);
    set_ir(8'h07);
    repeat (4) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o, a_o}, {2'b01, 8'h96})
    set_ir(8'h02);
    i_tap_ctrl_model.scan(18, 18'h10000, q);
    set_ir(8'h07);
    repeat (4) @(negedge clk_i);
    `CHK({b_oe_o, a_oe_o}, 2'b00)
  endtask : t_dir

  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    t_select();
    t_bypass();
    t_pins();
    t_self();
    t_run();
    t_dir();
    end_sim();
  end

  // The tests need about 1900 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end
endmodule : testbench

// file: inc/bscan_pkg.sv
// Shared constants and types for the boundary test instruction logic.
package bscan_pkg;
  // ------------------------------------------------------------------
  // Boundary cell chain layout
  // ------------------------------------------------------------------
  localparam int BSR_LEN = 18;
  localparam int DATA_W = 8;
  localparam int DIR_BIT = 17;
  localparam int OE_BIT = 16;
  localparam int IN_LSB = 8;
  localparam int OUT_LSB = 0;
  localparam int PIN_W = 2 * DATA_W + 2;
  localparam int SIG16_W = 16;
  localparam int SIG8_W = 8;

  // ------------------------------------------------------------------
  // Operation select register and bypass register
  // ------------------------------------------------------------------
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h2;
  localparam logic [SEL_W-1:0] OP_TOGGLE = 2'h0;
  localparam logic [SEL_W-1:0] OP_GEN16 = 2'h1;
  localparam logic [SEL_W-1:0] OP_SIG16 = 2'h2;
  localparam logic [SEL_W-1:0] OP_MIX8 = 2'h3;
  localparam logic BYPASS_CAPTURE = 1'b0;

  // ------------------------------------------------------------------
  // Instruction codes with the top bit dropped
  // ------------------------------------------------------------------
  localparam int INSTR_W = 8;
  localparam int OPC_W = 7;
  localparam logic [OPC_W-1:0] OPC_EXTEST = 7'h00;
  localparam logic [OPC_W-1:0] OPC_BYPASS = 7'h01;
  localparam logic [OPC_W-1:0] OPC_SAMPLE = 7'h02;
  localparam logic [OPC_W-1:0] OPC_INTEST = 7'h03;
  localparam logic [OPC_W-1:0] OPC_HIGHZ = 7'h06;
  localparam logic [OPC_W-1:0] OPC_CLAMP = 7'h07;
  localparam logic [OPC_W-1:0] OPC_RUN_BOUNDARY_TEST = 7'h09;
  localparam logic [OPC_W-1:0] OPC_READN = 7'h0a;
  localparam logic [OPC_W-1:0] OPC_READT = 7'h0b;
  localparam logic [OPC_W-1:0] OPC_SELFTEST = 7'h0c;
  localparam logic [OPC_W-1:0] OPC_TOGGLE = 7'h0d;
  localparam logic [OPC_W-1:0] OPC_SELN = 7'h0e;
  localparam logic [OPC_W-1:0] OPC_SELT = 7'h0f;

  // ------------------------------------------------------------------
  // Feedback polynomials, Galois form, both maximal length
  // ------------------------------------------------------------------
  localparam logic [SIG16_W-1:0] POLY16 = 16'h002d;
  localparam logic [SIG8_W-1:0] POLY8 = 8'h1d;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {DR_BYPASS, DR_BOUNDARY, DR_SELECT} dr_sel_e;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_TEST, MODE_HIGHZ} mode_e;
  typedef enum logic [1:0] {CAP_PINS, CAP_HOLD, CAP_INVERT} capture_e;

  typedef struct packed {
    dr_sel_e dr;
    mode_e mode;
    capture_e cap;
    logic run_op;
    logic toggle_only;
  } decode_s;

  // TAP state levels plus one-cycle test clock edge enables.
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic tlr;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic run_idle;
  } tap_s;
endpackage : bscan_pkg

// file: rtl/boundary_test_exec.sv
// Boundary test instruction execution for an octal bus transceiver.
`timescale 1ns/1ps

// How it works
// - Boundary scan: cells drive core and pins.
// - Bypass: one bit, captures zero, normal mode.
// - Sample: chain captures pins, normal mode.
// - High-Z: bypass, outputs floated, core works.
// - Clamp: bypass, cells drive core and pins.
// - Run test: bypass, test mode, run operation.
// - Boundary read: chain held at capture.
// - Self test: cells capture own complement.
// - Toggle: output stages invert, latch on fall.
// - Toggle: input cells held, drive core.
// - Select scan: register kept at capture.
// - Select codes: toggle, gen16, sig16, mixed8.
// - Control cells excluded, still steer drive.
// - Sample/toggle: inputs captured then latched.
// - Sample/toggle: outputs invert, latched on fall.
// - Gen16: sixteen-bit pattern, latched on fall.
// - Controller seeds chain; zero seed stalls.
// - Sig16: fold inputs, hold output latches.
// - Mixed: 8-bit signature and 8-bit pattern.
// - Unknown instruction codes act as bypass.
// - Select register resets to signature mode.
// - Instruction top bit is ignored.
module boundary_test_exec (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire bscan_pkg::tap_s tap_i,
  input wire logic [bscan_pkg::INSTR_W-1:0] instr_i,
  input wire logic tdi_i,
  output logic tdo_o,
  input wire logic dir_i,
  input wire logic oe_n_i,
  input wire logic [bscan_pkg::DATA_W-1:0] a_i,
  output logic [bscan_pkg::DATA_W-1:0] a_o,
  output logic a_oe_o,
  input wire logic [bscan_pkg::DATA_W-1:0] b_i,
  output logic [bscan_pkg::DATA_W-1:0] b_o,
  output logic b_oe_o,
  output logic test_mode_o
);
  // ------------------------------------------------------------------
  // Local shorthands
  // ------------------------------------------------------------------
  localparam int N = bscan_pkg::BSR_LEN;
  localparam int DW = bscan_pkg::DATA_W;
  localparam int IL = bscan_pkg::IN_LSB;
  localparam int OL = bscan_pkg::OUT_LSB;
  localparam int S16 = bscan_pkg::SIG16_W;
  localparam int SW = bscan_pkg::SEL_W;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [bscan_pkg::PIN_W-1:0] pin_meta_ff;
  logic [bscan_pkg::PIN_W-1:0] pin_sync_ff;
  logic dir_pin;
  logic oe_n_pin;
  logic [DW-1:0] a_pin;
  logic [DW-1:0] b_pin;
  bscan_pkg::decode_s dec;
  logic [N-1:0] chain_ff;
  logic [N-1:0] nxt_chain;
  logic [N-1:0] shadow_ff;
  logic [N-1:0] nxt_shadow;
  logic bypass_ff;
  logic [SW-1:0] sel_ff;
  logic tdo_ff;
  logic [DW-1:0] chain_in;
  logic [DW-1:0] chain_out;
  logic [DW-1:0] shadow_in;
  logic [DW-1:0] shadow_out;
  logic is_test;
  logic is_highz;
  logic eff_dir;
  logic eff_oe_n;
  logic [DW-1:0] in_term;
  logic [DW-1:0] core_in;
  logic [DW-1:0] core_out;
  logic [DW-1:0] out_term;
  logic drive;
  logic [S16-1:0] gen16_next;
  logic [S16-1:0] sig16_next;
  logic [DW-1:0] sig8_next;
  logic [DW-1:0] gen8_next;
  logic run_now;
  logic toggle_now;
  logic [DW-1:0] a_o_ff;
  logic [DW-1:0] b_o_ff;
  logic a_oe_ff;
  logic b_oe_ff;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Terminals come from outside the clock domain, so two flops each.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= {dir_i, oe_n_i, a_i, b_i};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Only the second stage is looked at.
  assign dir_pin = pin_sync_ff[2*DW+1];
  assign oe_n_pin = pin_sync_ff[2*DW];
  assign a_pin = pin_sync_ff[DW +: DW];
  assign b_pin = pin_sync_ff[0 +: DW];

  // ------------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------------
  instr_decode u_decode (
    .instr_i(instr_i),
    .dec_o(dec)
  );

  // ------------------------------------------------------------------
  // Cell views
  // ------------------------------------------------------------------
  // Slices of the data cells; control cells 17 and 16 stand apart.
  assign chain_in = chain_ff[IL +: DW];
  assign chain_out = chain_ff[OL +: DW];
  assign shadow_in = shadow_ff[IL +: DW];
  assign shadow_out = shadow_ff[OL +: DW];

  // ------------------------------------------------------------------
  // Mode control and transceiver path
  // ------------------------------------------------------------------
  // Test mode hands direction and enable to the control cells.
  assign is_test = (dec.mode == bscan_pkg::MODE_TEST);
  assign is_highz = (dec.mode == bscan_pkg::MODE_HIGHZ);
  assign eff_dir = is_test ? shadow_ff[bscan_pkg::DIR_BIT] : dir_pin;
  assign eff_oe_n = is_test ? shadow_ff[bscan_pkg::OE_BIT] : oe_n_pin;

  // Direction high means A is the input side and B is driven.
  assign in_term = eff_dir ? a_pin : b_pin;

  // In test mode the core sees the input latches, not the pins.
  assign core_in = is_test ? shadow_in : in_term;
  assign core_out = core_in;

  // Output latches replace the core result at the pins in test mode.
  assign out_term = is_test ? shadow_out : core_out;

  // High-Z keeps the core running but floats every output terminal.
  assign drive = !is_highz && !eff_oe_n;

  // ------------------------------------------------------------------
  // Feedback networks
  // ------------------------------------------------------------------
  // Sixteen-bit pattern generator over the data cells.
  lfsr_step #(
    .W(S16),
    .POLY(bscan_pkg::POLY16)
  ) u_gen16 (
    .state_i(chain_ff[S16-1:0]),
    .data_i('0),
    .next_o(gen16_next)
  );

  // Sixteen-bit signature; inputs fold into the input cell half.
  lfsr_step #(
    .W(S16),
    .POLY(bscan_pkg::POLY16)
  ) u_sig16 (
    .state_i(chain_ff[S16-1:0]),
    .data_i({in_term, {DW{1'b0}}}),
    .next_o(sig16_next)
  );

  // Eight-bit signature kept in the input cells.
  lfsr_step #(
    .W(bscan_pkg::SIG8_W),
    .POLY(bscan_pkg::POLY8)
  ) u_sig8 (
    .state_i(chain_in),
    .data_i(in_term),
    .next_o(sig8_next)
  );

  // Eight-bit pattern generator kept in the output cells.
  lfsr_step #(
    .W(bscan_pkg::SIG8_W),
    .POLY(bscan_pkg::POLY8)
  ) u_gen8 (
    .state_i(chain_out),
    .data_i('0),
    .next_o(gen8_next)
  );

  // ------------------------------------------------------------------
  // Run-Test/Idle qualifiers
  // ------------------------------------------------------------------
  // Operations only step while the TAP idles in Run-Test/Idle.
  assign run_now = tap_i.run_idle && dec.run_op;
  assign toggle_now = tap_i.run_idle && dec.toggle_only;

  // ------------------------------------------------------------------
  // Boundary cell shift stages
  // ------------------------------------------------------------------
  // Shift stages move on the rising test clock edge only.
  always_comb begin
    nxt_chain = chain_ff;
    if (tap_i.tck_rise) begin
      if (tap_i.capture_dr && dec.dr == bscan_pkg::DR_BOUNDARY) begin
        unique case (dec.cap)
          bscan_pkg::CAP_PINS: begin
            nxt_chain = {dir_pin, oe_n_pin, in_term, core_out};
          end
          bscan_pkg::CAP_HOLD: begin
            nxt_chain = chain_ff;
          end
          bscan_pkg::CAP_INVERT: begin
            nxt_chain = ~chain_ff;
          end
          default: begin
            nxt_chain = chain_ff;
          end
        endcase
      end else if (tap_i.shift_dr && dec.dr == bscan_pkg::DR_BOUNDARY) begin
        nxt_chain = {tdi_i, chain_ff[N-1:1]};
      end else if (toggle_now) begin
        // Input stages are left alone; pins are not sampled.
        nxt_chain[OL +: DW] = ~chain_out;
      end else if (run_now) begin
        // Control cells 17 and 16 are never touched here.
        unique case (sel_ff)
          bscan_pkg::OP_TOGGLE: begin
            nxt_chain[IL +: DW] = in_term;
            nxt_chain[OL +: DW] = ~chain_out;
          end
          bscan_pkg::OP_GEN16: begin
            nxt_chain[S16-1:0] = gen16_next;
          end
          bscan_pkg::OP_SIG16: begin
            nxt_chain[S16-1:0] = sig16_next;
          end
          bscan_pkg::OP_MIX8: begin
            nxt_chain[IL +: DW] = sig8_next;
            nxt_chain[OL +: DW] = gen8_next;
          end
        endcase
      end
    end
  end

  // The chain keeps its seed across reset only as zero.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= nxt_chain;
    end
  end

  // ------------------------------------------------------------------
  // Shadow latches
  // ------------------------------------------------------------------
  // Shadows follow the shift stages on the falling test clock edge.
  always_comb begin
    nxt_shadow = shadow_ff;
    if (tap_i.tck_fall) begin
      if (tap_i.update_dr && dec.dr == bscan_pkg::DR_BOUNDARY) begin
        nxt_shadow = chain_ff;
      end else if (toggle_now) begin
        nxt_shadow[OL +: DW] = chain_out;
      end else if (run_now) begin
        unique case (sel_ff)
          bscan_pkg::OP_TOGGLE: begin
            nxt_shadow[IL +: DW] = chain_in;
            nxt_shadow[OL +: DW] = chain_out;
          end
          bscan_pkg::OP_GEN16: begin
            nxt_shadow[S16-1:0] = chain_ff[S16-1:0];
          end
          bscan_pkg::OP_SIG16: begin
            // Output latches stay put so the pins do not move.
            nxt_shadow[IL +: DW] = chain_in;
          end
          bscan_pkg::OP_MIX8: begin
            nxt_shadow[IL +: DW] = chain_in;
            nxt_shadow[OL +: DW] = chain_out;
          end
        endcase
      end
    end
  end

  // Shadow storage.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      shadow_ff <= '0;
    end else begin
      shadow_ff <= nxt_shadow;
    end
  end

  // ------------------------------------------------------------------
  // Bypass register
  // ------------------------------------------------------------------
  // Bypass always loads zero at Capture-DR when it is selected.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      bypass_ff <= bscan_pkg::BYPASS_CAPTURE;
    end else if (tap_i.tck_rise && dec.dr == bscan_pkg::DR_BYPASS) begin
      if (tap_i.capture_dr) begin
        bypass_ff <= bscan_pkg::BYPASS_CAPTURE;
      end else if (tap_i.shift_dr) begin
        bypass_ff <= tdi_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Operation select register
  // ------------------------------------------------------------------
  // Shifts straight into its stages; a scan under run test goes to the
  // bypass bit and leaves the operation alone; the controller loads it beforehand.
  always_ff @(posedge clk_i) begin
    if (!resetn_i || tap_i.tlr) begin
      sel_ff <= bscan_pkg::SEL_RESET;
    end else if (tap_i.tck_rise && tap_i.shift_dr &&
                 dec.dr == bscan_pkg::DR_SELECT) begin
      sel_ff <= {tdi_i, sel_ff[SW-1:1]};
    end
  end

  // ------------------------------------------------------------------
  // Serial output
  // ------------------------------------------------------------------
  // Serial data leaves on the falling edge during Shift-DR.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tdo_ff <= 1'b0;
    end else if (tap_i.tck_fall && tap_i.shift_dr) begin
      unique case (dec.dr)
        bscan_pkg::DR_BOUNDARY: tdo_ff <= chain_ff[0];
        bscan_pkg::DR_SELECT: tdo_ff <= sel_ff[0];
        bscan_pkg::DR_BYPASS: tdo_ff <= bypass_ff;
        default: tdo_ff <= bypass_ff;
      endcase
    end
  end

  assign tdo_o = tdo_ff;

  // ------------------------------------------------------------------
  // Terminal drivers
  // ------------------------------------------------------------------
  // Registered so the pins never glitch on decode changes.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      a_o_ff <= '0;
      b_o_ff <= '0;
      a_oe_ff <= 1'b0;
      b_oe_ff <= 1'b0;
    end else begin
      a_o_ff <= out_term;
      b_o_ff <= out_term;
      a_oe_ff <= drive && !eff_dir;
      b_oe_ff <= drive && eff_dir;
    end
  end

  assign a_o = a_o_ff;
  assign b_o = b_o_ff;
  assign a_oe_o = a_oe_ff;
  assign b_oe_o = b_oe_ff;
  assign test_mode_o = is_test;
endmodule : boundary_test_exec

// file: rtl/instr_decode.sv
// Instruction decoder: register selection, mode and capture kind.
`timescale 1ns/1ps

module instr_decode (
  input wire logic [bscan_pkg::INSTR_W-1:0] instr_i,
  output bscan_pkg::decode_s dec_o
);
  // The top bit is never looked at; unknown codes fall back to bypass.
  always_comb begin
    dec_o.dr = bscan_pkg::DR_BYPASS;
    dec_o.mode = bscan_pkg::MODE_NORMAL;
    dec_o.cap = bscan_pkg::CAP_HOLD;
    dec_o.run_op = 1'b0;
    dec_o.toggle_only = 1'b0;
    unique case (instr_i[bscan_pkg::OPC_W-1:0])
      bscan_pkg::OPC_EXTEST, bscan_pkg::OPC_INTEST: begin
        dec_o.dr = bscan_pkg::DR_BOUNDARY;
        dec_o.mode = bscan_pkg::MODE_TEST;
        dec_o.cap = bscan_pkg::CAP_PINS;
      end
      bscan_pkg::OPC_SAMPLE: begin
        dec_o.dr = bscan_pkg::DR_BOUNDARY;
        dec_o.cap = bscan_pkg::CAP_PINS;
      end
      bscan_pkg::OPC_HIGHZ: begin
        dec_o.mode = bscan_pkg::MODE_HIGHZ;
      end
      bscan_pkg::OPC_CLAMP: begin
        dec_o.mode = bscan_pkg::MODE_TEST;
      end
      bscan_pkg::OPC_RUN_BOUNDARY_TEST: begin
        dec_o.mode = bscan_pkg::MODE_TEST;
        dec_o.run_op = 1'b1;
      end
      bscan_pkg::OPC_READN: begin
        dec_o.dr = bscan_pkg::DR_BOUNDARY;
      end
      bscan_pkg::OPC_READT: begin
        dec_o.dr = bscan_pkg::DR_BOUNDARY;
        dec_o.mode = bscan_pkg::MODE_TEST;
      end
      bscan_pkg::OPC_SELFTEST: begin
        dec_o.dr = bscan_pkg::DR_BOUNDARY;
        dec_o.cap = bscan_pkg::CAP_INVERT;
      end
      bscan_pkg::OPC_TOGGLE: begin
        dec_o.mode = bscan_pkg::MODE_TEST;
        dec_o.toggle_only = 1'b1;
      end
      bscan_pkg::OPC_SELN: begin
        dec_o.dr = bscan_pkg::DR_SELECT;
      end
      bscan_pkg::OPC_SELT: begin
        dec_o.dr = bscan_pkg::DR_SELECT;
        dec_o.mode = bscan_pkg::MODE_TEST;
      end
      default: begin
        dec_o.dr = bscan_pkg::DR_BYPASS;
      end
    endcase
  end
endmodule : instr_decode

// file: rtl/lfsr_step.sv
// One step of a Galois feedback register with parallel data folding.
`timescale 1ns/1ps

module lfsr_step #(
  parameter int W = bscan_pkg::SIG16_W,
  parameter logic [W-1:0] POLY = bscan_pkg::POLY16
) (
  input wire logic [W-1:0] state_i,
  input wire logic [W-1:0] data_i,
  output logic [W-1:0] next_o
);
  // Zero data makes a pattern generator; an all-zero seed stays zero.
  always_comb begin
    next_o = {state_i[W-2:0], 1'b0} ^ data_i;
    if (state_i[W-1]) begin
      next_o = next_o ^ POLY;
    end
  end
endmodule : lfsr_step
